// ---- common/evf_pkg.sv ----
// Purpose: constants and carrier types for the group A/B event flag block
// Assumes: 16-bit core data bus, 16-bit word addresses
// Notes:   vector register addresses are local to this block

package evf_pkg;

    // register word addresses
    localparam logic [15:0] EVF_MASK_A_ADDR = 16'h742C;
    localparam logic [15:0] EVF_MASK_B_ADDR = 16'h742D;
    localparam logic [15:0] EVF_FLAG_A_ADDR = 16'h742F;
    localparam logic [15:0] EVF_FLAG_B_ADDR = 16'h7430;
    localparam logic [15:0] EVF_VEC_A_ADDR  = 16'h7432;
    localparam logic [15:0] EVF_VEC_B_ADDR  = 16'h7433;

    // group widths and reset values
    localparam int          EVF_GRP_A_W     = 11;
    localparam int          EVF_GRP_B_W     = 8;
    localparam logic [15:0] EVF_FLAG_RESET  = 16'h0000;
    localparam logic [15:0] EVF_MASK_RESET  = 16'h0000;

    // vector identifiers: base is the top-priority source of a group
    localparam logic [7:0]  EVF_VEC_BASE_A  = 8'h20;
    localparam logic [7:0]  EVF_VEC_BASE_B  = 8'h2B;
    localparam logic [7:0]  EVF_VEC_NONE    = 8'h00;

    // group A field positions
    localparam int EVF_A_PROTECT_BIT = 0;
    localparam int EVF_A_FCMP1_BIT   = 1;
    localparam int EVF_A_SCMP1_BIT   = 4;
    localparam int EVF_A_T1_PER_BIT  = 7;
    localparam int EVF_A_T1_CMP_BIT  = 8;
    localparam int EVF_A_T1_UNF_BIT  = 9;
    localparam int EVF_A_T1_OVF_BIT  = 10;
    // group B field positions
    localparam int EVF_B_T2_PER_BIT  = 0;
    localparam int EVF_B_T3_PER_BIT  = 4;
    localparam int EVF_B_T3_OVF_BIT  = 7;

    // one bus cycle from the core
    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [15:0] wdata;
    } evf_bus_req_t;

    // group A source events, msb first so bit n is field n
    typedef struct packed {
        logic timer1Overflow;
        logic timer1Underflow;
        logic timer1Compare;
        logic timer1Period;
        logic simpleCmp3;
        logic simpleCmp2;
        logic simpleCmp1;
        logic fullCmp3;
        logic fullCmp2;
        logic fullCmp1;
        logic driveProtect;
    } evf_grp_a_evt_t;

    // group B source events
    typedef struct packed {
        logic timer3Overflow;
        logic timer3Underflow;
        logic timer3Compare;
        logic timer3Period;
        logic timer2Overflow;
        logic timer2Underflow;
        logic timer2Compare;
        logic timer2Period;
    } evf_grp_b_evt_t;

endpackage

// ---- dv/evf_core_model.sv ----
// Purpose: core side of the data bus, one access at a time
// Assumes: requests change at falling edges, block samples on rising
// Notes:   a released bus shows inverted address and data, not zeros
`timescale 1ns/1ps
`default_nettype none

module evf_core_model
    import evf_pkg::*;
(
    input  wire logic         core_clk,   // system clock
    output var  evf_bus_req_t busReq,     // bus cycle to the block
    input  wire logic [15:0]  busRdata,   // read data
    input  wire logic         busRdValid  // read data strobe
);
    // idle bus at time zero
    initial begin
        busReq = '{16'h0000, 1'b0, 1'b0, 16'h0000};
    end

    // one access: hold for one rising edge, take the answer one cycle on
    task automatic access(input logic [15:0] a, input logic r,
                          input logic w, input logic [15:0] d,
                          output logic [15:0] q, output logic v);
        @(negedge core_clk);
        busReq = '{a, r, w, d};
        @(negedge core_clk);
        q = busRdata;
        v = busRdValid;
        busReq = '{~a, 1'b0, 1'b0, ~d};  // stale values must not count
    endtask
endmodule

`default_nettype wire

// ---- dv/evf_event_flags_test.sv ----
// Purpose: self-checking bench for the group A/B event flag block
// Assumes: core model drives the bus, bench drives events at falling edge
// Notes:   flags, masks and vector picks are mirrored in integers
`timescale 1ns/1ps
`default_nettype none

module evf_event_flags_test;
    import evf_pkg::*;

    logic           core_clk;    // 40 MHz clock
    logic           rst_b;       // async reset
    evf_bus_req_t   busReq;      // bus cycle from core model
    logic [15:0]    busRdata;    // read data
    logic           busRdValid;  // read strobe
    evf_grp_a_evt_t grpAEvents;  // group A sources
    evf_grp_b_evt_t grpBEvents;  // group B sources
    logic           irqTwo_b;    // group A request
    logic           irqThree_b;  // group B request
    int             mismatches;  // failed compares
    int             compares;    // compares made
    int             cycles;      // timeout count
    int             fa, fb, ma, mb;
    logic [15:0]    rdQ;
    logic           vldQ;
    logic [15:0]    addrs [7] = '{EVF_MASK_A_ADDR, EVF_MASK_B_ADDR,
        EVF_FLAG_A_ADDR, EVF_FLAG_B_ADDR, EVF_VEC_A_ADDR, EVF_VEC_B_ADDR,
        16'h7431};

    // clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    evf_event_flags dut_u (
        .core_clk           (core_clk),
        .rst_b              (rst_b),
        .busReq             (busReq),
        .busRdata           (busRdata),
        .busRdValid         (busRdValid),
        .grpAEvents         (grpAEvents),
        .grpBEvents         (grpBEvents),
        .coreIrqLineTwo_b   (irqTwo_b),
        .coreIrqLineThree_b (irqThree_b)
    );

    evf_core_model core_u (
        .core_clk   (core_clk),
        .busReq     (busReq),
        .busRdata   (busRdata),
        .busRdValid (busRdValid)
    );

    // verdict and end of run
    task automatic stop_test();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        compares++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    // lowest set and enabled bit wins and is cleared
    function automatic int vec(inout int f, input int m, input int base);
        int id;
        id = 0;
        for (int i = 15; i >= 0; i--)
            if (f[i] & m[i]) id = base + i;
        if (id != 0) f &= ~(1 << (id - base));
        return id;
    endfunction

    // model answer: valid bit above the data word
    function automatic logic [16:0] expect_rd(input logic [15:0] a);
        case (a)
            EVF_MASK_A_ADDR: return {1'b1, 16'(ma)};
            EVF_MASK_B_ADDR: return {1'b1, 16'(mb)};
            EVF_FLAG_A_ADDR: return {1'b1, 16'(fa)};
            EVF_FLAG_B_ADDR: return {1'b1, 16'(fb)};
            EVF_VEC_A_ADDR: return {1'b1, 16'(vec(fa, ma, EVF_VEC_BASE_A))};
            EVF_VEC_B_ADDR: return {1'b1, 16'(vec(fb, mb, EVF_VEC_BASE_B))};
            default: return 17'h00000;
        endcase
    endfunction

    task automatic rd_chk(input logic [15:0] a);
        logic [16:0] e;
        e = expect_rd(a);
        core_u.access(a, 1'b1, 1'b0, 16'h0000, rdQ, vldQ);
        check(rdQ, e[15:0]);
        check({15'h0000, vldQ}, {15'h0000, e[16]});
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        core_u.access(a, 1'b0, 1'b1, d, rdQ, vldQ);
        case (a)
            EVF_MASK_A_ADDR: ma = d & 16'h07FF;
            EVF_MASK_B_ADDR: mb = d & 16'h00FF;
            EVF_FLAG_A_ADDR: fa &= ~d;
            EVF_FLAG_B_ADDR: fb &= ~d;
            default: ;
        endcase
    endtask

    // one-cycle event pulse on both groups
    task automatic pulse(input logic [10:0] a, input logic [7:0] b);
        @(negedge core_clk);
        grpAEvents = a;
        grpBEvents = b;
        @(negedge core_clk);
        grpAEvents = '0;
        grpBEvents = '0;
        fa |= a;
        fb |= b;
    endtask

    // request lines settle one cycle after a flag change
    task automatic irq_chk();
        repeat (2) @(negedge core_clk);
        check({15'h0000, irqTwo_b}, {15'h0000, (fa & ma) == 0});
        check({15'h0000, irqThree_b}, {15'h0000, (fb & mb) == 0});
    endtask

    // timeout
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    // main sequence
    initial begin
        rst_b = 1'b0;
        grpAEvents = '0;
        grpBEvents = '0;
        {mismatches, compares, cycles, fa, fb, ma, mb} = '0;
        void'($urandom(32'h0a0ab930));
        repeat (16) @(negedge core_clk);
        rst_b = 1'b1;
        foreach (addrs[i]) rd_chk(addrs[i]);
        wr(EVF_MASK_A_ADDR, 16'hFFFF);
        wr(EVF_MASK_B_ADDR, 16'hFFFF);
        // each source alone in its group: flag position, vector id, request line
        for (int i = 0; i < 11; i++) begin
            pulse(11'(1 << i), 8'(1 << i));
            irq_chk();
            rd_chk(EVF_FLAG_A_ADDR);
            rd_chk(EVF_FLAG_B_ADDR);
            rd_chk(EVF_VEC_A_ADDR);
            rd_chk(EVF_VEC_B_ADDR);
            irq_chk();
        end
        // event and write-one-clear in one cycle: the set wins
        fork
            pulse(11'h0F0, 8'h0F);
            wr(EVF_FLAG_B_ADDR, 16'h00FF);
        join
        fb = 32'h0000000F;
        rd_chk(EVF_FLAG_B_ADDR);
        // reset in mid-run with every flag set
        pulse(11'h7FF, 8'hFF);
        rst_b = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        {fa, fb, ma, mb} = '0;
        foreach (addrs[i]) rd_chk(addrs[i]);
        irq_chk();
        // random events, masks, clears and reads
        for (int n = 0; n < 300; n++) begin
            pulse(11'($urandom), 8'($urandom));
            wr(addrs[$urandom % 7], 16'($urandom));
            irq_chk();
            rd_chk(addrs[$urandom % 7]);
        end
        stop_test();
    end
endmodule

`default_nettype wire

// ---- rtl/evf_event_flags.sv ----
// Purpose: group A and B event flag, mask and vector registers
// Assumes: single-cycle read and write strobes on the core data bus
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

module evf_event_flags
    import evf_pkg::*;
(
    input  wire logic           core_clk,             // 40 MHz clock
    input  wire logic           rst_b,                // async reset
    input  wire evf_bus_req_t   busReq,               // core bus cycle
    output logic     [15:0]     busRdata,             // registered data
    output logic                busRdValid,           // read data strobe
    input  wire evf_grp_a_evt_t grpAEvents,           // group A sources
    input  wire evf_grp_b_evt_t grpBEvents,           // group B sources
    output logic                coreIrqLineTwo_b,     // group A request
    output logic                coreIrqLineThree_b    // group B request
);

    // address decode
    logic selMaskA;
    logic selMaskB;
    logic selFlagA;
    logic selFlagB;
    logic selVecA;
    logic selVecB;
    logic selAny;

    assign selMaskA = busReq.addr == EVF_MASK_A_ADDR;
    assign selMaskB = busReq.addr == EVF_MASK_B_ADDR;
    assign selFlagA = busReq.addr == EVF_FLAG_A_ADDR;
    assign selFlagB = busReq.addr == EVF_FLAG_B_ADDR;
    assign selVecA  = busReq.addr == EVF_VEC_A_ADDR;
    assign selVecB  = busReq.addr == EVF_VEC_B_ADDR;
    assign selAny   = selMaskA | selMaskB | selFlagA | selFlagB
                    | selVecA | selVecB;

    // write-one-to-clear strobes, upper bits dropped
    logic [EVF_GRP_A_W-1:0] clrA;
    logic [EVF_GRP_B_W-1:0] clrB;
    logic                   vecRdA;
    logic                   vecRdB;

    assign clrA   = (busReq.wr && selFlagA) ?
                    busReq.wdata[EVF_GRP_A_W-1:0] : '0;
    assign clrB   = (busReq.wr && selFlagB) ?
                    busReq.wdata[EVF_GRP_B_W-1:0] : '0;
    assign vecRdA = busReq.rd && selVecA;
    assign vecRdB = busReq.rd && selVecB;

    // group mask registers
    logic [EVF_GRP_A_W-1:0] maskA_q;
    logic [EVF_GRP_B_W-1:0] maskB_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            maskA_q <= EVF_MASK_RESET[EVF_GRP_A_W-1:0];
            maskB_q <= EVF_MASK_RESET[EVF_GRP_B_W-1:0];
        end else if (busReq.wr) begin
            if (selMaskA) begin
                maskA_q <= busReq.wdata[EVF_GRP_A_W-1:0];
            end
            if (selMaskB) begin
                maskB_q <= busReq.wdata[EVF_GRP_B_W-1:0];
            end
        end
    end

    // the two flag groups
    logic [EVF_GRP_A_W-1:0] flagsA;
    logic [EVF_GRP_B_W-1:0] flagsB;
    logic                   pendingA;
    logic                   pendingB;
    logic [7:0]             vecIdA;
    logic [7:0]             vecIdB;

    evf_flag_bank #(
        .WIDTH      (EVF_GRP_A_W),
        .VEC_BASE   (EVF_VEC_BASE_A)
    ) u_bank_a (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .eventIn    (grpAEvents),
        .clearW1c   (clrA),
        .enableMask (maskA_q),
        .vecRead    (vecRdA),
        .flags      (flagsA),
        .pending    (pendingA),
        .vecId      (vecIdA)
    );

    evf_flag_bank #(
        .WIDTH      (EVF_GRP_B_W),
        .VEC_BASE   (EVF_VEC_BASE_B)
    ) u_bank_b (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .eventIn    (grpBEvents),
        .clearW1c   (clrB),
        .enableMask (maskB_q),
        .vecRead    (vecRdB),
        .flags      (flagsB),
        .pending    (pendingB),
        .vecId      (vecIdB)
    );

    // read mux, unused bits and unmapped addresses read zero
    logic [15:0] rdMux;

    assign rdMux = selFlagA ? 16'(flagsA) :
                   selFlagB ? 16'(flagsB) :
                   selMaskA ? 16'(maskA_q) :
                   selMaskB ? 16'(maskB_q) :
                   selVecA  ? 16'(vecIdA) :
                   selVecB  ? 16'(vecIdB) : 16'h0000;

    // registered read data and request lines
    logic [15:0] rdata_q;
    logic        rdValid_q;
    logic        irqTwo_b_q;
    logic        irqThree_b_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q      <= 16'h0000;
            rdValid_q    <= 1'b0;
            irqTwo_b_q   <= 1'b1;
            irqThree_b_q <= 1'b1;
        end else begin
            if (busReq.rd) begin
                rdata_q <= rdMux;
            end
            rdValid_q    <= busReq.rd && selAny;
            irqTwo_b_q   <= ~pendingA;
            irqThree_b_q <= ~pendingB;
        end
    end

    assign busRdata           = rdata_q;
    assign busRdValid         = rdValid_q;
    assign coreIrqLineTwo_b   = irqTwo_b_q;
    assign coreIrqLineThree_b = irqThree_b_q;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    logic [EVF_GRP_A_W-1:0] evA;
    logic [EVF_GRP_B_W-1:0] evB;
    assign evA = grpAEvents;
    assign evB = grpBEvents;

    a_upper_zero_a: assert property (
        busReq.rd && selFlagA |=> busRdata[15:11] == 5'h00)
        else $error("group A upper bits not zero");

    b_upper_zero_a: assert property (
        busReq.rd && selFlagB |=> busRdata[15:8] == 8'h00)
        else $error("group B upper bits not zero");

    a_w1c_clear_a: assert property (
        busReq.wr && selFlagA |=>
        (flagsA & $past(busReq.wdata[10:0] & ~evA)) == '0)
        else $error("group A write one did not clear");

    b_w0_keep_a: assert property (
        busReq.wr && selFlagB && !vecRdB |=>
        (flagsB & $past(flagsB & ~busReq.wdata[7:0])) ==
        $past(flagsB & ~busReq.wdata[7:0]))
        else $error("group B write zero changed a flag");

    event_sets_a: assert property (
        |evA |=> (flagsA & $past(evA)) == $past(evA))
        else $error("group A event lost");

    t1_unf_place_a: assert property (
        grpAEvents.timer1Underflow |=> flagsA[EVF_A_T1_UNF_BIT])
        else $error("timer 1 underflow flag misplaced");

    t3_per_place_a: assert property (
        grpBEvents.timer3Period |=> flagsB[EVF_B_T3_PER_BIT])
        else $error("timer 3 period flag misplaced");

    a_readback_a: assert property (
        busReq.rd && selFlagA |=> busRdata[10:0] == $past(flagsA))
        else $error("group A read data wrong");

    b_readback_a: assert property (
        busReq.rd && selFlagB |=> busRdata[7:0] == $past(flagsB))
        else $error("group B read data wrong");

    irq_two_a: assert property (
        ##1 !coreIrqLineTwo_b == $past(|(flagsA & maskA_q)))
        else $error("line two disagrees with enabled flags");

    irq_three_a: assert property (
        ##1 !coreIrqLineThree_b == $past(|(flagsB & maskB_q)))
        else $error("line three disagrees with enabled flags");

    vec_clears_a: assert property (
        vecRdA && pendingA && evA == '0 |=>
        $countones(flagsA) == $countones($past(flagsA)) - 1)
        else $error("vector read did not clear one flag");

    vec_none_a: assert property (
        vecRdB && !pendingB |=> busRdata == 16'h0000)
        else $error("idle vector read not zero");

    // main scenarios
    cov_vec_two_c: cover property (
        vecRdA && $countones(flagsA & maskA_q) > 1);
    cov_set_clear_c: cover property (
        busReq.wr && selFlagB && |(busReq.wdata[7:0] & evB));
    cov_irq_c: cover property ($fell(coreIrqLineTwo_b));

endmodule

`default_nettype wire

// ---- rtl/evf_flag_bank.sv ----
// Purpose: one group of sticky event flags with mask and vector lookup
// Assumes: bit 0 has the highest priority in the group
// Notes:   an event in the clearing cycle keeps its flag set
`timescale 1ns/1ps
`default_nettype none

module evf_flag_bank
    import evf_pkg::*;
#(
    parameter int         WIDTH    = EVF_GRP_B_W,
    parameter logic [7:0] VEC_BASE = EVF_VEC_BASE_B
) (
    input  wire logic             core_clk,   // system clock
    input  wire logic             rst_b,      // async reset, active low
    input  wire logic [WIDTH-1:0] eventIn,    // source event pulses
    input  wire logic [WIDTH-1:0] clearW1c,   // write-one-to-clear bits
    input  wire logic [WIDTH-1:0] enableMask, // group mask, 1 = enabled
    input  wire logic             vecRead,    // vector register read
    output logic      [WIDTH-1:0] flags,      // flag state
    output logic                  pending,    // any set and enabled
    output logic      [7:0]       vecId       // top-priority identifier
);

    logic [WIDTH-1:0] flag_q;
    logic [WIDTH-1:0] active;
    logic [WIDTH-1:0] winner;
    logic [WIDTH-1:0] vecClear;

    // enabled flags and the lowest-index one as one-hot
    assign active   = flag_q & enableMask;
    assign winner   = active & (~active + WIDTH'(1));
    assign vecClear = vecRead ? winner : '0;
    assign pending  = |active;
    assign flags    = flag_q;

    // identifier of the winning flag, zero when none
    always_comb begin
        vecId = EVF_VEC_NONE;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (active[i]) begin
                vecId = VEC_BASE + 8'(i);
            end
        end
    end

    // per-bit sticky flag, set beats clear
    for (genvar i = 0; i < WIDTH; i++) begin : g_flag
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                flag_q[i] <= EVF_FLAG_RESET[i];
            end else if (eventIn[i]) begin
                flag_q[i] <= 1'b1;
            end else if (clearW1c[i] | vecClear[i]) begin
                flag_q[i] <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire
